// ---- rtl/bcrs_pkg.sv ----
package bcrs_pkg;
   // pll divider triple
   typedef struct packed {
      logic [2:0]  out_div;
      logic [11:0] fb_mul;
      logic [5:0]  in_div;
   } bcrs_pll_type;

   // boot decisions handed to the tiles
   typedef struct packed {
      logic jtag_wait;
      logic reserved;
      logic t0_link;
      logic t0_spi;
      logic t1_chanend;
      logic t1_spi;
      logic indep_links;
      logic otp_boot;
   } bcrs_boot_type;

   // security register bits
   localparam int SEC_BOOT_BIT   = 5;
   localparam int SEC_JTAG_BIT   = 0;
   localparam int SEC_LINK_BIT   = 1;
   localparam int SEC_DEBUG_BIT  = 2;
   localparam int SEC_MLOCK_BIT  = 3;
   localparam int SEC_SLOCK_LSB  = 6;
   localparam int SEC_SECTORS    = 4;
   localparam int SEC_WIDTH      = 32;

   // strap table
   localparam bcrs_pll_type PLL_CODE00 = '{3'h1, 12'h07a, 6'h00}; // 1/122/0
   localparam bcrs_pll_type PLL_CODE11 = '{3'h2, 12'h077, 6'h00}; // 2/119/0
   localparam bcrs_pll_type PLL_CODE10 = '{3'h2, 12'h031, 6'h00}; // 2/49/0
   localparam bcrs_pll_type PLL_CODE01 = '{3'h2, 12'h017, 6'h00}; // 2/23/0

   // timing
   localparam int    CLK_MHZ        = 200;
   localparam int    RESET_CLOCKS   = 750000;
   localparam int    LINK_DELAY_NS  = 200;
   localparam int    LINK_DELAY_CYC = (LINK_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int    STRAP_EDGE     = 3;
   localparam int    SPI_CORE_MHZ   = 400;
   localparam int    SPI_SCLK_KHZ   = 2500;
   localparam int    SPI_HALF_CYC   = (CLK_MHZ * 1000) / (SPI_SCLK_KHZ * 2);
endpackage

// ---- rtl/bcrs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcrs_top #(
   parameter int RESET_COUNT = bcrs_pkg::RESET_CLOCKS
) (
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   input  wire logic                  ext_reset_n_i,
   input  wire logic                  supplies_good_i,
   input  wire logic                  watchdog_expired_i,
   input  wire logic                  watchdog_flag_clear_i,
   input  wire logic                  osc_source_select_n_i,
   input  wire logic                  pll_ratio_strap_hi_i,
   input  wire logic                  pll_ratio_strap_lo_i,
   input  wire logic [2:0]            boot_source_straps_i,
   input  wire logic                  otp_sec_valid_i,
   input  wire logic [31:0]           otp_sec_word_i,
   input  wire logic                  otp_copy_done_i,
   input  wire logic                  otp_req_i,
   input  wire logic [1:0]            otp_req_sector_i,
   input  wire logic                  pll_write_i,
   input  wire bcrs_pkg::bcrs_pll_type pll_write_data_i,
   input  wire logic                  link_pin_19_i,
   input  wire logic                  link_pin_20_i,
   output logic                       chip_reset_o,
   output logic                       gpio_pull_en_o,
   output logic                       use_ext_osc_o,
   output bcrs_pkg::bcrs_pll_type     pll_config_o,
   output bcrs_pkg::bcrs_boot_type    boot_sel_o,
   output logic                       boot_start_o,
   output logic                       otp_load_o,
   output logic                       otp_copy_run_o,
   output logic                       otp_grant_o,
   output logic                       jtag_blocked_o,
   output logic                       switch_blocked_o,
   output logic                       debug_pin_disabled_o,
   output logic                       spi_pins_en_o,
   output logic                       spi_sclk_o,
   output logic                       link_b_en_o,
   output logic                       link_pins_pd_en_o,
   output logic                       link_pin_16_o,
   output logic                       link_pin_16_oe_o,
   output logic                       link_pin_17_o,
   output logic                       link_pin_17_oe_o,
   output logic                       link_traffic_o,
   output logic                       watchdog_reset_flag_o
);
   import bcrs_pkg::*;

   typedef enum logic [5:0] {
      ST_RESET = 6'b00_0001,
      ST_COUNT = 6'b00_0010,
      ST_SEC   = 6'b00_0100,
      ST_COPY  = 6'b00_1000,
      ST_BOOT  = 6'b01_0000,
      ST_RUN   = 6'b10_0000
   } bcrs_state_type;

   // strap code to divider triple
   function automatic bcrs_pll_type pll_from_code(input logic [1:0] code);
      case (code)
         2'b00:   pll_from_code = PLL_CODE00;
         2'b11:   pll_from_code = PLL_CODE11;
         2'b10:   pll_from_code = PLL_CODE10;
         default: pll_from_code = PLL_CODE01;
      endcase
   endfunction
   // any reset source; watchdog reboots like the rest
   logic raw_reset;
   assign raw_reset = !ext_reset_n_i || !supplies_good_i || watchdog_expired_i;

   // release synchroniser: assert on the next edge, release after two edges
   logic sync1, sync2;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end else begin
         sync1 <= raw_reset;
         sync2 <= sync1 | raw_reset;
      end
   end

   bcrs_state_type state, next_state;
   logic [19:0]    count, next_count;
   logic [1:0]     strap_cnt, next_strap_cnt;
   logic [1:0]     pll_code, next_pll_code;
   logic           ext_osc, next_ext_osc;
   bcrs_pll_type   pll, next_pll;
   bcrs_boot_type  boot, next_boot;
   logic [31:0]    sec, next_sec;
   logic           wd_flag, next_wd_flag;
   logic [7:0]     link_cnt, next_link_cnt;
   logic [7:0]     spi_cnt, next_spi_cnt;
   logic           sclk, next_sclk;
   logic           link_en, next_link_en;
   logic           grant, next_grant;
   logic           traffic, next_traffic;
   // sequencer next state
   always_comb begin
      next_state     = state;
      next_count     = count;
      next_strap_cnt = strap_cnt;
      next_pll_code  = pll_code;
      next_ext_osc   = ext_osc;
      next_pll       = pll;
      next_boot      = boot;
      next_sec       = sec;
      next_link_cnt  = link_cnt;
      next_link_en   = link_en;
      case (state)
         ST_RESET: begin
            next_count     = '0;
            next_strap_cnt = '0;
            next_link_cnt  = '0;
            next_link_en   = 1'b0;
            next_state     = ST_COUNT;
         end
         ST_COUNT: begin
            // straps are still static until the third edge
            if (strap_cnt < 2'(STRAP_EDGE)) begin
               next_strap_cnt = strap_cnt + 2'd1;
               next_pll_code  = {pll_ratio_strap_hi_i, pll_ratio_strap_lo_i};
               next_ext_osc   = !osc_source_select_n_i;
               next_pll       = pll_from_code({pll_ratio_strap_hi_i, pll_ratio_strap_lo_i});
            end
            if (count >= 20'(RESET_COUNT - 1)) begin
               next_state = ST_SEC;
            end else begin
               next_count = count + 20'd1;
            end
         end
         ST_SEC: begin
            if (otp_sec_valid_i) begin
               next_sec   = otp_sec_word_i;
               next_state = ST_COPY;
            end
         end
         ST_COPY: begin
            if (otp_copy_done_i) begin
               next_state = ST_BOOT;
            end
         end
         ST_BOOT: begin
            next_boot = '0;
            if (sec[SEC_BOOT_BIT]) begin
               next_boot.otp_boot = 1'b1;
            end else begin
               case (boot_source_straps_i)
                  3'b000, 3'b100: next_boot.jtag_wait = 1'b1;
                  3'b001, 3'b101: next_boot.reserved = 1'b1;
                  3'b010: begin
                     next_boot.t0_link    = 1'b1;
                     next_boot.t1_chanend = 1'b1;
                  end
                  3'b011: begin
                     next_boot.t0_spi     = 1'b1;
                     next_boot.t1_chanend = 1'b1;
                  end
                  3'b110: next_boot.indep_links = 1'b1;
                  default: begin
                     next_boot.t0_spi = 1'b1;
                     next_boot.t1_spi = 1'b1;
                  end
               endcase
            end
            next_state = ST_RUN;
         end
         ST_RUN: begin
            // link b comes up a fixed delay after boot starts
            if ((boot.t0_link || boot.indep_links) && !link_en) begin
               if (link_cnt >= 8'(LINK_DELAY_CYC - 1)) begin
                  next_link_en = 1'b1;
               end else begin
                  next_link_cnt = link_cnt + 8'd1;
               end
            end
            if (pll_write_i) begin
               next_pll = pll_write_data_i;
            end
         end
         default: next_state = ST_RESET;
      endcase
      if (sync2) begin
         next_state = ST_RESET;
      end
   end
   // sequencer registers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state     <= ST_RESET;
         count     <= '0;
         strap_cnt <= '0;
         pll_code  <= 2'b00;
         ext_osc   <= 1'b0;
         pll       <= PLL_CODE00;
         boot      <= '0;
         sec       <= '0;
         link_cnt  <= '0;
         link_en   <= 1'b0;
      end else begin
         state     <= next_state;
         count     <= next_count;
         strap_cnt <= next_strap_cnt;
         pll_code  <= next_pll_code;
         ext_osc   <= next_ext_osc;
         pll       <= next_pll;
         boot      <= next_boot;
         sec       <= next_sec;
         link_cnt  <= next_link_cnt;
         link_en   <= next_link_en;
      end
   end
   // watchdog flag, sticky; expiry wins over a clear
   always_comb begin
      next_wd_flag = wd_flag;
      if (watchdog_flag_clear_i) begin
         next_wd_flag = 1'b0;
      end
      if (watchdog_expired_i) begin
         next_wd_flag = 1'b1;
      end
   end
   // otp access gate and link traffic watch
   always_comb begin
      next_grant   = otp_req_i && !sec[SEC_MLOCK_BIT]
                     && !sec[SEC_SLOCK_LSB + 32'(otp_req_sector_i)];
      next_traffic = link_en && (link_pin_19_i || link_pin_20_i);
   end
   // spi clock divider: only runs while spi boot is live
   always_comb begin
      next_spi_cnt = spi_cnt;
      next_sclk    = sclk;
      if (state == ST_RUN && (boot.t0_spi || boot.t1_spi)) begin
         if (spi_cnt >= 8'(SPI_HALF_CYC - 1)) begin
            next_spi_cnt = '0;
            next_sclk    = !sclk;
         end else begin
            next_spi_cnt = spi_cnt + 8'd1;
         end
      end else begin
         next_spi_cnt = '0;
         next_sclk    = 1'b0;
      end
   end
   // flag survives chip reset so boot code can read it
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wd_flag <= 1'b0;
         grant   <= 1'b0;
         traffic <= 1'b0;
         spi_cnt <= '0;
         sclk    <= 1'b0;
      end else begin
         wd_flag <= next_wd_flag;
         grant   <= next_grant;
         traffic <= next_traffic;
         spi_cnt <= next_spi_cnt;
         sclk    <= next_sclk;
      end
   end
   // output flops
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         chip_reset_o          <= 1'b1;
         gpio_pull_en_o        <= 1'b0;
         use_ext_osc_o         <= 1'b0;
         pll_config_o          <= PLL_CODE00;
         boot_sel_o            <= '0;
         boot_start_o          <= 1'b0;
         otp_load_o            <= 1'b0;
         otp_copy_run_o        <= 1'b0;
         otp_grant_o           <= 1'b0;
         jtag_blocked_o        <= 1'b0;
         switch_blocked_o      <= 1'b0;
         debug_pin_disabled_o  <= 1'b0;
         spi_pins_en_o         <= 1'b0;
         spi_sclk_o            <= 1'b0;
         link_b_en_o           <= 1'b0;
         link_pins_pd_en_o     <= 1'b1;
         link_pin_16_o         <= 1'b0;
         link_pin_16_oe_o      <= 1'b0;
         link_pin_17_o         <= 1'b0;
         link_pin_17_oe_o      <= 1'b0;
         link_traffic_o        <= 1'b0;
         watchdog_reset_flag_o <= 1'b0;
      end else begin
         chip_reset_o          <= (state == ST_RESET) || (state == ST_COUNT);
         gpio_pull_en_o        <= (state == ST_SEC) || (state == ST_COPY) || (state == ST_BOOT)
                                  || (state == ST_RUN);
         use_ext_osc_o         <= ext_osc;
         pll_config_o          <= pll;
         boot_sel_o            <= boot;
         boot_start_o          <= (state == ST_BOOT);
         otp_load_o            <= (state == ST_SEC);
         otp_copy_run_o        <= (state == ST_COPY);
         otp_grant_o           <= grant;
         jtag_blocked_o        <= sec[SEC_JTAG_BIT];
         switch_blocked_o      <= sec[SEC_LINK_BIT];
         debug_pin_disabled_o  <= sec[SEC_DEBUG_BIT];
         spi_pins_en_o         <= (state == ST_RUN) && (boot.t0_spi || boot.t1_spi);
         spi_sclk_o            <= sclk && (state == ST_RUN) && (boot.t0_spi || boot.t1_spi);
         link_b_en_o           <= link_en;
         link_pins_pd_en_o     <= !link_en;
         link_pin_16_o         <= 1'b0;
         link_pin_16_oe_o      <= link_en;
         link_pin_17_o         <= 1'b0;
         link_pin_17_oe_o      <= link_en;
         link_traffic_o        <= traffic;
         watchdog_reset_flag_o <= wd_flag;
      end
   end

   // reset holds while the supply or external reset source holds it; sync, state and output flop take three edges
   hold_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (!supplies_good_i || !ext_reset_n_i) |-> ##3 chip_reset_o)
      else $error("reset not held under fault");
   count_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(state == ST_SEC) |-> $past(count) == 20'(RESET_COUNT - 1))
      else $error("reset count wrong length");
   sequence link_wait_s;
      (state == ST_RUN && boot.t0_link && !sync2) [*8];
   endsequence
   link_delay_a: assert property (@(posedge clock_i) disable iff (rst_i || sync2)
      $rose(state == ST_RUN) && boot.t0_link |-> link_wait_s ##33 link_en)
      else $error("link b late");
   wd_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
      watchdog_expired_i |=> ##1 watchdog_reset_flag_o)
      else $error("watchdog flag missing");
   otp_lock_a: assert property (@(posedge clock_i) disable iff (rst_i)
      sec[SEC_MLOCK_BIT] && $stable(sec) |=> !grant)
      else $error("otp granted under lock");
   secure_boot_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(state == ST_RUN) && sec[SEC_BOOT_BIT] |-> boot == bcrs_boot_type'(8'h01))
      else $error("secure boot not forced");
   strap_pll_a: assert property (@(posedge clock_i) disable iff (rst_i)
      state == ST_SEC && $past(state) == ST_COUNT |-> pll == pll_from_code(pll_code))
      else $error("pll not from straps");
   pll_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
      state == ST_RUN && pll_write_i && !sync2 |=> ##1 pll_config_o == $past(pll_write_data_i, 2))
      else $error("pll write lost");
   spi_en_a: assert property (@(posedge clock_i) disable iff (rst_i)
      spi_sclk_o != $past(spi_sclk_o) |-> spi_pins_en_o || $past(spi_pins_en_o))
      else $error("sclk without spi boot");
endmodule
`default_nettype wire

// ---- tb/bcrs_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcrs_partner (
   input  wire logic        clock_i,
   input  wire logic        ext_reset_n_i,
   input  wire logic [4:0]  strap_req_i,
   input  wire logic [31:0] sec_req_i,
   input  wire logic        slow_i,
   input  wire logic        traffic_i,
   input  wire logic        otp_load_i,
   input  wire logic        copy_run_i,
   input  wire logic        link_en_i,
   output logic [4:0]       straps_o,
   output logic             sec_valid_o,
   output logic [31:0]      sec_word_o,
   output logic             copy_done_o,
   output logic             pin19_o,
   output logic             pin20_o
);
   int  waited = 0;
   wire logic sec_ok = otp_load_i && waited >= (slow_i ? 6 : 0);
   initial begin
      straps_o    = 5'h00;
      sec_valid_o = 1'b0;
      sec_word_o  = 32'h0000_0000;
      copy_done_o = 1'b0;
      pin19_o     = 1'b0;
      pin20_o     = 1'b0;
   end
   // straps move only with the pin low, so capture never sees them change
   // otp word toggles when not valid, a stale value would hide a late take
   always @(negedge clock_i) begin
      if (!ext_reset_n_i) begin
         straps_o <= strap_req_i;
      end
      waited      <= (otp_load_i || copy_run_i) ? waited + 1 : 0;
      sec_valid_o <= sec_ok;
      sec_word_o  <= sec_ok ? sec_req_i : ~sec_word_o;
      copy_done_o <= copy_run_i && waited >= (slow_i ? 9 : 1);
      pin19_o     <= link_en_i && traffic_i;
      pin20_o     <= 1'b0;
   end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcrs_pkg::*;
   localparam int RST_CNT  = 20;
   localparam int LINK_CYC = 200 / 5;
   localparam int LIMIT    = 20000;
   logic          clock_i = 1'b0, rst_i = 1'b1, ext_reset_n_i = 1'b0, supplies_good_i = 1'b1;
   logic          watchdog_expired_i = 1'b0, watchdog_flag_clear_i = 1'b0, osc_source_select_n_i = 1'b1;
   logic          otp_req_i = 1'b0, pll_write_i = 1'b0, slow = 1'b0, traffic = 1'b0, boot_seen;
   logic [1:0]    otp_req_sector_i = 2'h0;
   logic [4:0]    strap_req = 5'h00, straps;
   logic [31:0]   sec_req = 32'h0000_0000, otp_sec_word_i;
   bcrs_pll_type  pll_write_data_i = '{3'h7, 12'hfff, 6'h3f};
   logic          otp_sec_valid_i, otp_copy_done_i, link_pin_19_i, link_pin_20_i;
   logic          chip_reset_o, gpio_pull_en_o, use_ext_osc_o, boot_start_o, otp_load_o, otp_copy_run_o;
   logic          otp_grant_o, jtag_blocked_o, switch_blocked_o, debug_pin_disabled_o, spi_pins_en_o, spi_sclk_o;
   logic          link_b_en_o, link_pins_pd_en_o, link_pin_16_o, link_pin_16_oe_o, link_pin_17_o, link_pin_17_oe_o;
   logic          link_traffic_o, watchdog_reset_flag_o;
   bcrs_pll_type  pll_config_o;
   bcrs_boot_type boot_sel_o;
   int            bad_count = 0, samples_checked = 0, cycles = 0;

   bcrs_top #(.RESET_COUNT(RST_CNT)) bcrs_top_i (
      .clock_i, .rst_i, .ext_reset_n_i, .supplies_good_i, .watchdog_expired_i, .watchdog_flag_clear_i,
      .osc_source_select_n_i, .pll_ratio_strap_hi_i(straps[4]), .pll_ratio_strap_lo_i(straps[3]),
      .boot_source_straps_i(straps[2:0]), .otp_sec_valid_i, .otp_sec_word_i, .otp_copy_done_i, .otp_req_i,
      .otp_req_sector_i, .pll_write_i, .pll_write_data_i, .link_pin_19_i, .link_pin_20_i, .chip_reset_o,
      .gpio_pull_en_o, .use_ext_osc_o, .pll_config_o, .boot_sel_o, .boot_start_o, .otp_load_o,
      .otp_copy_run_o, .otp_grant_o, .jtag_blocked_o, .switch_blocked_o, .debug_pin_disabled_o,
      .spi_pins_en_o, .spi_sclk_o, .link_b_en_o, .link_pins_pd_en_o, .link_pin_16_o, .link_pin_16_oe_o,
      .link_pin_17_o, .link_pin_17_oe_o, .link_traffic_o, .watchdog_reset_flag_o);
   bcrs_partner bcrs_partner_i (.clock_i, .ext_reset_n_i, .strap_req_i(strap_req), .sec_req_i(sec_req),
      .slow_i(slow), .traffic_i(traffic), .otp_load_i(otp_load_o), .copy_run_i(otp_copy_run_o),
      .link_en_i(link_b_en_o), .straps_o(straps), .sec_valid_o(otp_sec_valid_i), .sec_word_o(otp_sec_word_i),
      .copy_done_o(otp_copy_done_i), .pin19_o(link_pin_19_i), .pin20_o(link_pin_20_i));

   // 200 MHz
   always #2.5 clock_i = ~clock_i;
   // hang guard
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: run timed out", $time);
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check_bit(input logic act, input logic want, input string what);
      samples_checked++;
      if (act !== want) begin
         bad_count++;
         $display("unexpected at %0t: %s got %b", $time, what, act);
      end
   endtask
   task automatic check_pll(input bcrs_pll_type act, input bcrs_pll_type want);
      samples_checked++;
      if (act !== want) begin
         bad_count++;
         $display("unexpected at %0t: pll %h", $time, act);
      end
   endtask
   task automatic check_num(input int act, input int lo, input int hi, input string what);
      samples_checked++;
      if (act < lo || act > hi) begin
         bad_count++;
         $display("unexpected at %0t: %s %0d", $time, what, act);
      end
   endtask
   // ratio times 100, from the divider triple
   function automatic int ratio100(input bcrs_pll_type p);
      return (int'(p.fb_mul) + 1) * 100 / (2 * (int'(p.in_div) + 1) * (int'(p.out_div) + 1));
   endfunction

   // counts the held reset, pokes a pll write that must be ignored
   task automatic wait_boot();
      int n;
      n = 0;
      boot_seen = 1'b0;
      while (chip_reset_o === 1'b1 && n < 400) begin
         @(negedge clock_i);
         n++;
         pll_write_i = (n == 8);
      end
      check_num(n, RST_CNT, RST_CNT + 8, "reset length");
      for (int i = 0; i < 80 && !boot_seen; i++) begin
         @(posedge clock_i);
         #1 boot_seen = (boot_start_o === 1'b1);
      end
      repeat (3) @(negedge clock_i);
   endtask
   task automatic boot(input logic [4:0] code, input logic [31:0] sec, input logic osc_n);
      @(negedge clock_i);
      ext_reset_n_i = 1'b0;
      strap_req = code;
      sec_req = sec;
      osc_source_select_n_i = osc_n;
      repeat (4) @(negedge clock_i);
      check_bit(chip_reset_o, 1'b1, "reset held");
      check_bit(gpio_pull_en_o, 1'b0, "pulls in reset");
      ext_reset_n_i = 1'b1;
      wait_boot();
      check_bit(gpio_pull_en_o, 1'b1, "pulls on");
   endtask
   task automatic otp_access(input logic [1:0] s, input logic want);
      otp_req_sector_i = s;
      otp_req_i = 1'b1;
      repeat (3) @(negedge clock_i);
      check_bit(otp_grant_o, want, "otp grant");
      otp_req_i = 1'b0;
      repeat (3) @(negedge clock_i);
      check_bit(otp_grant_o, 1'b0, "grant drops");
   endtask

   task automatic t_pll_table();
      bcrs_pll_type want [4];
      int           rat [4];
      want = '{'{3'h1, 12'h07a, 6'h00}, '{3'h2, 12'h017, 6'h00}, '{3'h2, 12'h031, 6'h00}, '{3'h2, 12'h077, 6'h00}};
      rat = '{3075, 400, 833, 2000};
      for (int i = 0; i < 4; i++) begin
         boot({i[1:0], 3'h0}, 32'h0000_0000, i[0]);
         check_pll(pll_config_o, want[i]);
         check_num(ratio100(pll_config_o), rat[i], rat[i], "ratio");
         check_bit(use_ext_osc_o, ~i[0], "osc source");
         check_bit(jtag_blocked_o, 1'b0, "jtag open");
      end
   endtask
   task automatic t_boot_codes();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         boot({2'h3, c}, 32'h0000_0000, 1'b1);
         check_bit(boot_seen, 1'b1, "boot start");
         check_bit(boot_sel_o.t1_chanend, c == 3'h2 || c == 3'h3, "tile one chanend");
         check_bit(boot_sel_o.jtag_wait, c[1:0] == 2'h0, "jtag wait");
         check_bit(boot_sel_o.reserved, c[1:0] == 2'h1, "reserved");
         check_bit(boot_sel_o.t0_link, c == 3'h2, "link boot");
         check_bit(boot_sel_o.t0_spi, c[1:0] == 2'h3, "spi boot");
         check_bit(boot_sel_o.t1_spi, c == 3'h7, "tile one spi");
         check_bit(boot_sel_o.indep_links, c == 3'h6, "own links");
         check_bit(spi_pins_en_o, c[1:0] == 2'h3, "spi pins");
         check_bit(boot_sel_o.otp_boot, 1'b0, "no otp boot");
      end
   endtask
   task automatic t_link();
      int n;
      boot(5'h1a, 32'h0000_0000, 1'b1);
      n = 3;
      while (link_b_en_o !== 1'b1 && n < 200) begin
         @(negedge clock_i);
         n++;
      end
      check_num(n, LINK_CYC - 4, LINK_CYC + 6, "link delay");
      check_bit(link_pins_pd_en_o, 1'b0, "pull-downs off");
      check_bit(link_pin_16_oe_o & ~link_pin_16_o, 1'b1, "pin 16 low");
      check_bit(link_pin_17_oe_o & ~link_pin_17_o, 1'b1, "pin 17 low");
      check_bit(link_traffic_o, 1'b0, "quiet link");
      traffic = 1'b1;
      repeat (4) @(negedge clock_i);
      check_bit(link_traffic_o, 1'b1, "traffic seen");
      traffic = 1'b0;
   endtask
   task automatic t_spi();
      int n;
      boot(5'h1b, 32'h0000_0000, 1'b1);
      n = 0;
      while (spi_sclk_o !== 1'b1 && n < 400) begin
         @(posedge clock_i);
         #1 n++;
      end
      n = 0;
      while (spi_sclk_o === 1'b1 && n < 400) begin
         @(posedge clock_i);
         #1 n++;
      end
      check_num(n, 40, 40, "sclk half period");
   endtask
   // slow otp answer, secure boot over link straps
   task automatic t_security();
      slow = 1'b1;
      boot(5'h1a, 32'h0000_0027, 1'b1);
      slow = 1'b0;
      check_bit(boot_sel_o.otp_boot, 1'b1, "otp boot");
      check_bit(boot_sel_o.t0_link, 1'b0, "straps ignored");
      check_bit(jtag_blocked_o & switch_blocked_o & debug_pin_disabled_o, 1'b1, "locks");
      repeat (60) @(negedge clock_i);
      check_bit(link_b_en_o, 1'b0, "no link boot");
      boot(5'h18, 32'h0000_0100, 1'b1);
      for (int s = 0; s < 4; s++) otp_access(s[1:0], s != 2);
      boot(5'h18, 32'h0000_0008, 1'b1);
      for (int s = 0; s < 4; s++) otp_access(s[1:0], 1'b0);
   endtask
   task automatic t_pll_write();
      // 20 MHz x 100 / 2 = 1 GHz keeps the loop in band
      pll_write_data_i = '{3'h1, 12'h063, 6'h01};
      pll_write_i = 1'b1;
      @(negedge clock_i);
      pll_write_i = 1'b0;
      repeat (2) @(negedge clock_i);
      check_pll(pll_config_o, '{3'h1, 12'h063, 6'h01});
      check_num(ratio100(pll_config_o), 1250, 1250, "new ratio");
   endtask
   task automatic t_supply();
      supplies_good_i = 1'b0;
      repeat (4) @(negedge clock_i);
      check_bit(chip_reset_o, 1'b1, "supply reset");
      repeat (30) @(negedge clock_i);
      check_bit(chip_reset_o, 1'b1, "still held");
      supplies_good_i = 1'b1;
      wait_boot();
      check_bit(boot_seen, 1'b1, "cold reboot");
      check_pll(pll_config_o, '{3'h2, 12'h077, 6'h00});
   endtask
   task automatic t_watchdog();
      check_bit(watchdog_reset_flag_o, 1'b0, "flag clear");
      watchdog_expired_i = 1'b1;
      @(negedge clock_i);
      watchdog_expired_i = 1'b0;
      repeat (4) @(negedge clock_i);
      check_bit(chip_reset_o, 1'b1, "dog reset");
      wait_boot();
      check_bit(watchdog_reset_flag_o, 1'b1, "flag kept");
      watchdog_flag_clear_i = 1'b1;
      @(negedge clock_i);
      watchdog_flag_clear_i = 1'b0;
      repeat (2) @(negedge clock_i);
      check_bit(watchdog_reset_flag_o, 1'b0, "flag cleared");
   endtask

   initial begin
      repeat (20) @(negedge clock_i);
      rst_i = 1'b0;
      t_pll_table();
      t_boot_codes();
      t_link();
      t_spi();
      t_security();
      boot(5'h18, 32'h0000_0000, 1'b1);
      t_pll_write();
      t_supply();
      t_watchdog();
      results();
   end
endmodule
`default_nettype wire
